// ===== hw/dcdf_dev_end.sv
/*
  device end of the deep fifo core: memory, pointers, flags, port-size
  capture, mailbox bypass and mark/retransmit. assumes the controlling end
  on the same ref_clk drives every dev-modport input synchronously.
*/

module dcdf_dev_end #(
  parameter int DEPTH_LOG2 = dcdf_pkg::DEPTH_LOG2
) (
  input wire logic ref_clk,
  input wire logic rst,
  dcdf_link_if.dev lnk,
  output logic [dcdf_pkg::SEL_W-1:0] word_width_now,
  output logic [DEPTH_LOG2:0] fill_level
);

  localparam int AW = DEPTH_LOG2;
  localparam int PW = DEPTH_LOG2 + 1;
  localparam int DW = dcdf_pkg::DATA_W;

  // ==========================================================
  // storage and state
  logic [DW-1:0] mem [2**AW];
  logic [PW-1:0] wr_ptr_q, rd_ptr_q, mark_q;
  logic [PW-1:0] wr_ptr_d, rd_ptr_d;
  logic [dcdf_pkg::SEL_W-1:0] sel_q;
  logic mreset_prev_q;
  logic mbx_prev_q;
  logic full_q, empty_q;
  logic [DW-1:0] mbox_q;
  logic [PW-1:0] out_addr_q;

  // two-entry buffer between memory and output register
  logic [DW-1:0] buf_data_q [2];
  logic [PW-1:0] buf_addr_q [2];
  logic buf_show_q [2];
  logic buf_wp_q, buf_rp_q;
  logic [1:0] buf_cnt_q;

  // ==========================================================
  // decode
  logic [DW-1:0] lane_mask;
  logic [PW-1:0] capacity;
  logic [PW-1:0] full_at;
  logic [PW-1:0] count;
  logic [PW-1:0] count_d;
  logic [PW-1:0] count_even;
  logic clr;
  logic mreset_rise;
  logic do_wr, do_rd;
  logic buf_in_ready, buf_out_valid, buf_pop;
  logic pop_show;

  assign lane_mask = dcdf_pkg::dcdf_width_mask(sel_q);
  assign capacity = PW'(1) << (AW - dcdf_pkg::dcdf_depth_shift(sel_q));
  // the top locations stay empty as a sync guard
  assign full_at = capacity - PW'(dcdf_pkg::GUARD_WORDS);
  assign clr = ~lnk.master_reset_n | ~lnk.partial_reset_n;
  assign mreset_rise = ~mreset_prev_q & lnk.master_reset_n;
  assign count = wr_ptr_q - rd_ptr_q;
  assign count_even = {count[PW-1:1], 1'b0};

  // full blocks writes whatever the enable says
  assign do_wr = ~lnk.wr_en_n & full_q & ~lnk.bypass_select & ~clr;
  // empty blocks reads; the buffer's ready stalls the memory side
  assign do_rd = ~lnk.rd_en_n & empty_q & (count != '0) & buf_in_ready
               & ~lnk.bypass_select & ~clr;
  assign buf_in_ready = (buf_cnt_q != 2'h2);
  assign buf_out_valid = (buf_cnt_q != 2'h0);
  assign buf_pop = buf_out_valid & lnk.out_ready;
  assign pop_show = buf_pop & buf_show_q[buf_rp_q];

  always_comb begin
    wr_ptr_d = wr_ptr_q;
    rd_ptr_d = rd_ptr_q;
    if (clr) begin
      wr_ptr_d = '0;
      rd_ptr_d = '0;
    end else begin
      // pointer moves whether or not the input lanes are enabled
      if (do_wr) begin
        wr_ptr_d = wr_ptr_q + PW'(1);
      end
      if (lnk.retransmit_request) begin
        rd_ptr_d = mark_q;
      end else if (do_rd) begin
        rd_ptr_d = rd_ptr_q + PW'(1);
      end
    end
  end

  assign count_d = wr_ptr_d - rd_ptr_d;

  // ==========================================================
  // memory write: masked writes leave the location alone
  always_ff @(posedge ref_clk) begin
    if (do_wr & ~lnk.input_enable_n) begin
      mem[wr_ptr_q[AW-1:0]] <= lnk.d & lane_mask;
    end
  end

  // ==========================================================
  // pointers, size capture, mark
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      mark_q <= '0;
      mreset_prev_q <= 1'b0;
      sel_q <= dcdf_pkg::SEL_DEFAULT;
    end else begin
      wr_ptr_q <= wr_ptr_d;
      rd_ptr_q <= rd_ptr_d;
      mreset_prev_q <= lnk.master_reset_n;
      // size pins count only at the release of master reset
      if (mreset_rise) begin
        sel_q <= lnk.word_width_select;
      end
      if (clr) begin
        mark_q <= '0;
      end else if (lnk.mark) begin
        mark_q <= out_addr_q;
      end
    end
  end

  // ==========================================================
  // flags
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      full_q <= 1'b1;
      empty_q <= 1'b0;
    end else if (clr) begin
      full_q <= 1'b1;
      empty_q <= 1'b0;
    end else begin
      empty_q <= (count_d != '0);
      // the flag lags the pointer, the guard holds the late words
      if (full_q & (count_even >= full_at)) begin
        full_q <= 1'b0;
      end else if (~full_q
                   & (count <= full_at - PW'(dcdf_pkg::FULL_RELEASE_READS))) begin
        full_q <= 1'b1;
      end
    end
  end

  // ==========================================================
  // output buffer: a stalled reader loses no word
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      buf_wp_q <= 1'b0;
      buf_rp_q <= 1'b0;
      buf_cnt_q <= 2'h0;
    end else if (clr) begin
      buf_wp_q <= 1'b0;
      buf_rp_q <= 1'b0;
      buf_cnt_q <= 2'h0;
    end else begin
      if (do_rd) begin
        buf_wp_q <= ~buf_wp_q;
      end
      if (buf_pop) begin
        buf_rp_q <= ~buf_rp_q;
      end
      buf_cnt_q <= buf_cnt_q + {1'b0, do_rd} - {1'b0, buf_pop};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (do_rd) begin
      buf_data_q[buf_wp_q] <= mem[rd_ptr_q[AW-1:0]];
      buf_addr_q[buf_wp_q] <= rd_ptr_q;
      buf_show_q[buf_wp_q] <= ~lnk.output_enable_n;
    end
  end

  // ==========================================================
  // output register, data valid, lane enables, mailbox
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mbx_prev_q <= 1'b0;
      lnk.q <= '0;
      lnk.q_oe <= '0;
      lnk.output_word_valid_n <= 1'b1;
      out_addr_q <= '0;
      mbox_q <= '0;
    end else if (~(lnk.master_reset_n & mreset_prev_q)) begin
      // the latching edge clears too, so no lane drives at the old width
      mbx_prev_q <= 1'b0;
      lnk.q <= '0;
      lnk.q_oe <= '0;
      lnk.output_word_valid_n <= 1'b1;
      out_addr_q <= '0;
      mbox_q <= '0;
    end else begin
      // unused lanes never drive; oe high turns the whole bus off
      lnk.q_oe <= lnk.output_enable_n ? '0 : lane_mask;
      // valid goes low with the word itself
      lnk.output_word_valid_n <= ~pop_show;
      if (lnk.bypass_select) begin
        mbox_q <= lnk.d & lane_mask;
      end
      mbx_prev_q <= lnk.bypass_select;
      if (lnk.bypass_select & mbx_prev_q) begin
        lnk.q <= mbox_q;  // second edge of the mailbox path
      end else if (pop_show) begin
        lnk.q <= buf_data_q[buf_rp_q];
        out_addr_q <= buf_addr_q[buf_rp_q];
      end
    end
  end

  // ==========================================================
  // status toward local logic
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      lnk.full_indication_n <= 1'b1;
      lnk.empty_indication_n <= 1'b0;
      word_width_now <= dcdf_pkg::SEL_DEFAULT;
      fill_level <= '0;
    end else begin
      lnk.full_indication_n <= full_q;
      lnk.empty_indication_n <= empty_q;
      word_width_now <= sel_q;
      fill_level <= count_d;
    end
  end

endmodule

// ===== hw/dcdf_pkg.sv
/*
  constants, state codes and decode functions shared by both ends of the
  deep fifo core. assumes one clock, ref_clk at 125 MHz, for both ports.
*/
package dcdf_pkg;

  // ==========================================================
  // bus shape and depth
  localparam int DATA_W = 36;
  localparam int SEL_W = 3;
  localparam int DEPTH_LOG2 = 23;  // 8 Meg words at the narrowest size
  localparam logic [2:0] SEL_DEFAULT = 3'h7;

  // locations withheld from storage so the flags never falsely sync
  localparam int GUARD_WORDS = 8;
  // reads needed after full before the full flag may drop again
  localparam int FULL_RELEASE_READS = 2;

  // ==========================================================
  // timing of the host end
  localparam int CLK_PERIOD_NS = 8;
  localparam int RESET_HOLD_NS = 80;
  localparam int RESET_HOLD_CYC = (RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // quiet read-clock cycles before a mailbox transfer may start
  localparam int QUIET_CYC = 4;
  localparam int TMR_W = 8;

  // ==========================================================
  // host states
  typedef enum logic [3:0] {
    DCDF_ST_INIT = 4'h1,
    DCDF_ST_RUN = 4'h2,
    DCDF_ST_CLEAR = 4'h4,
    DCDF_ST_MBX = 4'h8
  } dcdf_state_t;

  // ==========================================================
  // port-size decode
  function automatic logic [DATA_W-1:0] dcdf_width_mask(input logic [SEL_W-1:0] sel);
    logic [DATA_W-1:0] m;
    m = '0;
    unique case (sel)
      3'h0: m = 36'h0_0000_01ff;
      3'h1: m = 36'h0_0000_0fff;
      3'h2: m = 36'h0_0000_ffff;
      3'h3: m = 36'h0_0003_ffff;
      3'h4: m = 36'h0_000f_ffff;
      3'h5: m = 36'h0_00ff_ffff;
      3'h6: m = 36'h0_ffff_ffff;
      3'h7: m = 36'hf_ffff_ffff;
    endcase
    return m;
  endfunction

  // depth is 8 Meg, 4 Meg or 2 Meg: shift down from the widest depth
  function automatic int dcdf_depth_shift(input logic [SEL_W-1:0] sel);
    int s;
    s = 2;
    if (sel == 3'h0) begin
      s = 0;
    end else if (sel <= 3'h3) begin
      s = 1;
    end
    return s;
  endfunction

endpackage

// ===== hw/dcdf_link_if.sv
/*
  link between the fifo device end and its controlling end.
  assumes both ends run on the same ref_clk; q_oe tells which q bits drive.
*/
interface dcdf_link_if;
  logic wr_en_n;
  logic input_enable_n;
  logic [dcdf_pkg::DATA_W-1:0] d;
  logic rd_en_n;
  logic output_enable_n;
  logic out_ready;
  logic [dcdf_pkg::DATA_W-1:0] q;
  logic [dcdf_pkg::DATA_W-1:0] q_oe;
  logic output_word_valid_n;
  logic mark;
  logic retransmit_request;
  logic bypass_select;
  logic master_reset_n;
  logic partial_reset_n;
  logic [dcdf_pkg::SEL_W-1:0] word_width_select;
  logic full_indication_n;
  logic empty_indication_n;

  modport dev (
    input wr_en_n, input_enable_n, d, rd_en_n, output_enable_n, out_ready,
    input mark, retransmit_request, bypass_select, master_reset_n,
    input partial_reset_n, word_width_select,
    output q, q_oe, output_word_valid_n, full_indication_n, empty_indication_n
  );

  modport host (
    output wr_en_n, input_enable_n, d, rd_en_n, output_enable_n, out_ready,
    output mark, retransmit_request, bypass_select, master_reset_n,
    output partial_reset_n, word_width_select,
    input q, q_oe, output_word_valid_n, full_indication_n, empty_indication_n
  );
endinterface

// ===== hw/dcdf_host_end.sv
/*
  controlling end of the deep fifo: resets the device, pairs writes,
  drains reads and runs mailbox transfers for user logic.
  assumes the device end on the same ref_clk across dcdf_link_if.
*/
module dcdf_host_end (
  input wire logic ref_clk,
  input wire logic rst,
  dcdf_link_if.host lnk,
  input wire logic [dcdf_pkg::SEL_W-1:0] usr_width,
  output logic host_ready,
  input wire logic usr_wr_valid,
  input wire logic [dcdf_pkg::DATA_W-1:0] usr_wr_data,
  input wire logic usr_wr_skip,
  output logic usr_wr_ready,
  input wire logic usr_rd_ready,
  input wire logic usr_rd_skip,
  output logic usr_rd_valid,
  output logic [dcdf_pkg::DATA_W-1:0] usr_rd_data,
  input wire logic usr_mark,
  input wire logic usr_retx,
  input wire logic usr_clear_req,
  input wire logic usr_mbx_req
);

  // ==========================================================
  // sequencing
  dcdf_pkg::dcdf_state_t st_q, st_d;
  logic [dcdf_pkg::TMR_W-1:0] tmr_q, tmr_d;
  logic [dcdf_pkg::DATA_W-1:0] pair_q [2];
  logic skip_q [2];
  logic [1:0] held_q, held_d;
  logic send_q;
  logic run;
  logic take;
  logic send_first;
  logic quiet;

  assign run = (st_q == dcdf_pkg::DCDF_ST_RUN);
  assign take = usr_wr_valid & usr_wr_ready;
  // a pair goes out back to back once both words are held
  assign send_first = run & (held_q == 2'h2) & ~send_q & lnk.full_indication_n;
  // a pair about to go out also breaks the quiet spell, so no write meets the mailbox
  assign quiet = lnk.output_word_valid_n & lnk.rd_en_n & ~send_q & ~send_first;
  assign held_d = send_q ? 2'h0 : (take ? held_q + 2'h1 : held_q);

  always_comb begin
    st_d = st_q;
    tmr_d = tmr_q + dcdf_pkg::TMR_W'(1);
    unique case (st_q)
      dcdf_pkg::DCDF_ST_INIT: begin
        // master reset is held before any access
        if (tmr_q == dcdf_pkg::TMR_W'(dcdf_pkg::RESET_HOLD_CYC)) begin
          st_d = dcdf_pkg::DCDF_ST_RUN;
          tmr_d = '0;
        end
      end
      dcdf_pkg::DCDF_ST_RUN: begin
        tmr_d = quiet ? tmr_q + dcdf_pkg::TMR_W'(1) : '0;
        if (usr_clear_req & ~send_q & ~send_first) begin
          st_d = dcdf_pkg::DCDF_ST_CLEAR;
          tmr_d = '0;
        end else if (usr_mbx_req & quiet & (tmr_q >= dcdf_pkg::TMR_W'(dcdf_pkg::QUIET_CYC))) begin
          st_d = dcdf_pkg::DCDF_ST_MBX;
        end
      end
      dcdf_pkg::DCDF_ST_CLEAR: begin
        // user asks for this to empty the fifo; the latched size stays until a master reset
        if (tmr_q == dcdf_pkg::TMR_W'(dcdf_pkg::RESET_HOLD_CYC)) begin
          st_d = dcdf_pkg::DCDF_ST_RUN;
          tmr_d = '0;
        end
      end
      dcdf_pkg::DCDF_ST_MBX: begin
        if (~usr_mbx_req) begin
          st_d = dcdf_pkg::DCDF_ST_RUN;
          tmr_d = '0;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_q <= dcdf_pkg::DCDF_ST_INIT;
      tmr_q <= '0;
      held_q <= 2'h0;
      send_q <= 1'b0;
    end else begin
      st_q <= st_d;
      tmr_q <= tmr_d;
      held_q <= held_d;
      send_q <= send_first;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (take) begin
      pair_q[held_q[0]] <= usr_wr_data;
      skip_q[held_q[0]] <= usr_wr_skip;
    end
  end

  // ==========================================================
  // pins, all from flops
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      lnk.master_reset_n <= 1'b0;
      lnk.partial_reset_n <= 1'b1;
      lnk.word_width_select <= dcdf_pkg::SEL_DEFAULT;
      lnk.wr_en_n <= 1'b1;
      lnk.input_enable_n <= 1'b1;
      lnk.d <= '0;
      lnk.rd_en_n <= 1'b1;
      lnk.output_enable_n <= 1'b1;
      lnk.out_ready <= 1'b0;
      lnk.mark <= 1'b0;
      lnk.retransmit_request <= 1'b0;
      lnk.bypass_select <= 1'b0;
      host_ready <= 1'b0;
      usr_wr_ready <= 1'b0;
      usr_rd_valid <= 1'b0;
      usr_rd_data <= '0;
    end else begin
      lnk.master_reset_n <= (st_d != dcdf_pkg::DCDF_ST_INIT);
      lnk.partial_reset_n <= (st_d != dcdf_pkg::DCDF_ST_CLEAR);
      lnk.word_width_select <= usr_width;
      lnk.wr_en_n <= ~(send_first | send_q);
      lnk.input_enable_n <= send_q ? skip_q[1] : skip_q[0];
      if (st_d == dcdf_pkg::DCDF_ST_MBX) begin
        lnk.d <= usr_wr_data;
      end else begin
        lnk.d <= send_q ? pair_q[1] : pair_q[0];
      end
      lnk.rd_en_n <= ~(run & usr_rd_ready & ~usr_mbx_req);
      lnk.output_enable_n <= usr_rd_skip;
      lnk.out_ready <= usr_rd_ready;
      lnk.mark <= run & usr_mark;
      lnk.retransmit_request <= run & usr_retx;
      lnk.bypass_select <= (st_d == dcdf_pkg::DCDF_ST_MBX);
      host_ready <= (st_d == dcdf_pkg::DCDF_ST_RUN);
      usr_wr_ready <= (st_d == dcdf_pkg::DCDF_ST_RUN) & (held_d != 2'h2);
      usr_rd_valid <= ~lnk.output_word_valid_n;
      usr_rd_data <= lnk.q;
    end
  end

endmodule

// ===== test/dcdf_assertions.sv
/*
  concurrent checks on the link between the two fifo ends.
  assumes one ref_clk and the active-high rst of that domain for everything.
*/
module dcdf_checker (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic wr_en_n,
  input wire logic [dcdf_pkg::DATA_W-1:0] d,
  input wire logic rd_en_n,
  input wire logic output_enable_n,
  input wire logic [dcdf_pkg::DATA_W-1:0] q,
  input wire logic [dcdf_pkg::DATA_W-1:0] q_oe,
  input wire logic output_word_valid_n,
  input wire logic bypass_select,
  input wire logic master_reset_n,
  input wire logic [dcdf_pkg::SEL_W-1:0] word_width_select,
  input wire logic full_indication_n,
  input wire logic empty_indication_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  // ==========================================================
  // shadow of the size latch, kept apart from the device's own copy
  localparam logic [5:0] LANES [8] = '{6'h09, 6'h0c, 6'h10, 6'h12, 6'h14, 6'h18, 6'h20, 6'h24};
  logic mreset_q;
  logic wr_odd_q;
  logic [2:0] width_q;
  logic [5:0] lane_bits;
  logic [35:0] lane_mask;
  assign lane_bits = LANES[width_q];
  assign lane_mask = (36'h1 << lane_bits) - 36'h1;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mreset_q <= 1'b0;
      wr_odd_q <= 1'b0;
      width_q <= dcdf_pkg::SEL_DEFAULT;
    end else begin
      mreset_q <= master_reset_n;
      wr_odd_q <= wr_odd_q ^ ~wr_en_n;
      if (master_reset_n && !mreset_q) begin
        width_q <= word_width_select;
      end
    end
  end

  // ==========================================================
  // properties
  sequence s_mbx_held;
    bypass_select [*3];
  endsequence

  sequence s_mreset_held;
    !master_reset_n [*3];
  endsequence

  a_mbx_two_cycles: assert property (s_mbx_held |-> ((q ^ $past(d, 2)) & lane_mask) == '0)
    else $error("mailbox word not on q two cycles after capture");
  a_mreset_clears: assert property (s_mreset_held |-> q == '0 && q_oe == '0
    && output_word_valid_n
    && full_indication_n && !empty_indication_n)
    else $error("master reset left output or flags set");
  a_lanes_unused: assert property (((q | q_oe) & ~lane_mask) == '0)
    else $error("lane above word width active");
  a_skip_undriven: assert property (output_enable_n [*2] |-> q_oe == '0)
    else $error("q driven while outputs disabled");
  a_valid_drives: assert property (!output_word_valid_n |-> q_oe == lane_mask)
    else $error("valid word shown without driven lanes");
  a_write_pairs: assert property ($rose(wr_en_n) |-> !wr_odd_q)
    else $error("odd total of writes");
  a_burst_min: assert property ($fell(wr_en_n) |=> !wr_en_n)
    else $error("write burst shorter than two");
  a_mbx_quiet: assert property (bypass_select |-> wr_en_n && rd_en_n && output_word_valid_n)
    else $error("fifo traffic during mailbox");
  a_no_early_access: assert property (!master_reset_n |-> wr_en_n && rd_en_n)
    else $error("access while master reset held");
endmodule

// ===== test/dual_clock_deep_fifo_core_test.sv
/*
  self-checking bench: host end and device end joined by dcdf_link_if,
  driven from the host's user side. assumes a shallow device (64 words, depth log2 of 6).
*/
module dual_clock_deep_fifo_core_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SIM_DEPTH_LOG2 = 6;
  localparam int WBITS [8] = '{9, 12, 16, 18, 20, 24, 32, 36};
  logic ref_clk;
  logic rst;
  logic [2:0] usr_width;
  logic host_ready;
  logic usr_wr_valid;
  logic [35:0] usr_wr_data;
  logic usr_wr_skip;
  logic usr_wr_ready;
  logic usr_rd_ready;
  logic usr_rd_skip;
  logic usr_rd_valid;
  logic [35:0] usr_rd_data;
  logic usr_mark;
  logic usr_retx;
  logic usr_clear_req;
  logic usr_mbx_req;
  logic [2:0] word_width_now;
  logic [SIM_DEPTH_LOG2:0] fill_level;
  logic [35:0] m;
  int errors;
  int cmp_count;
  int n;

  dcdf_link_if lnk ();
  dcdf_dev_end #(.DEPTH_LOG2(SIM_DEPTH_LOG2)) u_dcdf_dev_end (.ref_clk(ref_clk), .rst(rst),
    .lnk(lnk), .word_width_now(word_width_now), .fill_level(fill_level));
  dcdf_host_end u_dcdf_host_end (.ref_clk(ref_clk), .rst(rst), .lnk(lnk),
    .usr_width(usr_width), .host_ready(host_ready), .usr_wr_valid(usr_wr_valid),
    .usr_wr_data(usr_wr_data), .usr_wr_skip(usr_wr_skip), .usr_wr_ready(usr_wr_ready),
    .usr_rd_ready(usr_rd_ready), .usr_rd_skip(usr_rd_skip), .usr_rd_valid(usr_rd_valid),
    .usr_rd_data(usr_rd_data), .usr_mark(usr_mark), .usr_retx(usr_retx),
    .usr_clear_req(usr_clear_req), .usr_mbx_req(usr_mbx_req));
  dcdf_checker u_dcdf_checker (.ref_clk(ref_clk), .rst(rst), .wr_en_n(lnk.wr_en_n),
    .d(lnk.d), .rd_en_n(lnk.rd_en_n), .output_enable_n(lnk.output_enable_n), .q(lnk.q),
    .q_oe(lnk.q_oe), .output_word_valid_n(lnk.output_word_valid_n),
    .bypass_select(lnk.bypass_select), .master_reset_n(lnk.master_reset_n),
    .word_width_select(lnk.word_width_select), .full_indication_n(lnk.full_indication_n),
    .empty_indication_n(lnk.empty_indication_n));

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  // ==========================================================
  // helpers
  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk);
  endtask

  task automatic check(input logic [39:0] got, input logic [39:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t ns: seen %h expected %h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // waits on host_ready, so also usable after a partial reset
  task automatic wait_ready();
    int k;
    k = 0;
    while (host_ready !== 1'b1 && k < 60) begin
      tick(1);
      k++;
    end
    check(host_ready, 1'b1);
  endtask

  task automatic do_reset(input logic [2:0] w);
    rst <= 1'b1;
    usr_width <= w;
    tick(12);
    rst <= 1'b0;
    wait_ready();
    check(lnk.q, '0);
    check({lnk.full_indication_n, lnk.empty_indication_n}, 2'b10);
    // the size is latched one edge after release and shown one edge later
    tick(2);
    check(word_width_now, w);
  endtask

  // words go out in pairs only, since the writer may not leave an odd total
  task automatic put(input logic [35:0] v, input logic s);
    int k;
    usr_wr_valid <= 1'b1;
    usr_wr_data <= v;
    usr_wr_skip <= s;
    k = 0;
    do begin
      tick(1);
      k++;
    end while (usr_wr_ready !== 1'b1 && k < 100);
    check(usr_wr_ready, 1'b1);
  endtask

  task automatic put_pair(input logic [35:0] a, input logic [35:0] b, input logic sb);
    put(a, 1'b0);
    put(b, sb);
    usr_wr_valid <= 1'b0;
    // let an edge pass so a following pair never reassigns valid in this step
    tick(1);
  endtask

  task automatic get(input logic [35:0] exp);
    int k;
    k = 0;
    do begin
      tick(1);
      k++;
    end while (usr_rd_valid !== 1'b1 && k < 100);
    check({usr_rd_valid, usr_rd_data}, {1'b1, exp});
  endtask

  task automatic mbx(input logic [35:0] v, input logic [35:0] exp);
    int k;
    usr_wr_data <= v;
    usr_mbx_req <= 1'b1;
    k = 0;
    do begin
      tick(1);
      k++;
    end while (lnk.bypass_select !== 1'b1 && k < 60);
    tick(3);
    check(lnk.q, exp);
    usr_mbx_req <= 1'b0;
    tick(10);
  endtask

  // ==========================================================
  // tests
  initial begin
    rst = 1'b1;
    usr_width = 3'h7;
    usr_wr_valid = 1'b0;
    usr_wr_data = '0;
    usr_wr_skip = 1'b0;
    usr_rd_ready = 1'b0;
    usr_rd_skip = 1'b0;
    usr_mark = 1'b0;
    usr_retx = 1'b0;
    usr_clear_req = 1'b0;
    usr_mbx_req = 1'b0;
    errors = 0;
    cmp_count = 0;
    do_reset(3'h7);
    usr_rd_ready <= 1'b1;
    put_pair(36'h1_1111_0001, 36'h1_1111_0002, 1'b0);
    get(36'h1_1111_0001);
    get(36'h1_1111_0002);
    usr_clear_req <= 1'b1;
    tick(2);
    usr_clear_req <= 1'b0;
    tick(2);
    wait_ready();
    check(lnk.empty_indication_n, 1'b0);
    // masked second word leaves the old word in place after pointers rewind
    put_pair(36'h2_2222_0001, 36'h2_2222_0002, 1'b1);
    get(36'h2_2222_0001);
    get(36'h1_1111_0002);
    usr_rd_skip <= 1'b1;
    put_pair(36'h3_3333_0001, 36'h3_3333_0002, 1'b0);
    n = 0;
    repeat (20) begin
      tick(1);
      if (usr_rd_valid === 1'b1) n++;
    end
    check(n, 0);
    usr_rd_skip <= 1'b0;
    put_pair(36'h4_4444_0001, 36'h4_4444_0002, 1'b0);
    get(36'h4_4444_0001);
    get(36'h4_4444_0002);
    put_pair(36'h6_6666_0001, 36'h6_6666_0002, 1'b0);
    get(36'h6_6666_0001);
    get(36'h6_6666_0002);
    usr_rd_ready <= 1'b0;
    tick(4);
    usr_mark <= 1'b1;
    tick(1);
    usr_mark <= 1'b0;
    tick(4);
    usr_retx <= 1'b1;
    tick(1);
    usr_retx <= 1'b0;
    usr_rd_ready <= 1'b1;
    get(36'h6_6666_0002);
    tick(6);
    check(lnk.empty_indication_n, 1'b0);
    // x36 holds 16 words here, eight of them withheld as guard
    usr_rd_ready <= 1'b0;
    for (int i = 0; i < 4; i++) put_pair(36'h5_0000_0000 + 2 * i, 36'h5_0000_0001 + 2 * i, 1'b0);
    tick(6);
    check(lnk.full_indication_n, 1'b0);
    check(fill_level, 8);
    usr_rd_ready <= 1'b1;
    for (int i = 0; i < 8; i++) get(36'h5_0000_0000 + i);
    tick(4);
    check({lnk.full_indication_n, fill_level}, {1'b1, 7'h00});
    for (int c = 0; c < 8; c++) begin
      do_reset(c[2:0]);
      usr_width <= ~c[2:0];
      m = (36'h1 << WBITS[c]) - 36'h1;
      usr_rd_ready <= 1'b1;
      put_pair(36'hf_ffff_ffff, 36'h5_5555_5555, 1'b0);
      get(m);
      get(36'h5_5555_5555 & m);
      check(lnk.q_oe, m);
      check(word_width_now, c);
      mbx(36'hf_ffff_ffff, m);
    end
    summarize();
  end

  initial begin
    tick(30000);
    errors++;
    summarize();
  end
endmodule
